// File: core/dscr_pkg.sv
/*
  Shared constants for the converter configuration register bank:
  register indexes on both pages, field positions, reset values,
  bus encodings and the bus state type.
  Assumes a 32-bit AHB-Lite register bus with one register per aligned word.
*/
`default_nettype none

package dscr_pkg;

  // ************************************************************
  // Page windows on the register bus
  // ************************************************************
  localparam logic [31:0] DIGITAL_PAGE_BASE = 32'h0000_0000;
  localparam logic [31:0] ANALOG_PAGE_BASE = 32'h0000_0400;
  localparam int unsigned PAGE_SPAN_BITS = 10;  // 256 indexes, 4 bytes each

  // ************************************************************
  // Register indexes (byte address = page base + 4 * index)
  // ************************************************************
  localparam logic [7:0] DOWNCONV_MODE_CD_IDX = 8'hAE;
  localparam logic [7:0] TRIM_LOAD_COMMAND_IDX = 8'hB7;
  localparam logic [7:0] CORE_STATUS_IDX = 8'hF0;
  localparam logic [7:0] SYSREF_GATE_CONTROL_IDX = 8'h6A;
  localparam logic [7:0] SERIAL_SWING_SELECT_IDX = 8'h6F;
  localparam logic [7:0] LANE_AB_EMPHASIS_IDX = 8'h71;
  localparam logic [7:0] LANE_B_EMPHASIS_LOW_IDX = 8'h72;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned TRIM_BIT = 0;
  localparam int unsigned SYSREF_MASK_BIT = 1;
  localparam int unsigned SWING_LSB = 4;
  localparam int unsigned SWING_W = 3;
  localparam int unsigned LANE_A_LSB = 0;
  localparam int unsigned DEEMPH_W = 6;
  localparam int unsigned LANE_B_UP_LSB = 6;
  localparam int unsigned LANE_B_UP_W = 2;
  localparam int unsigned LANE_B_LOW_LSB = 0;
  localparam int unsigned LANE_B_LOW_W = 4;
  localparam int unsigned STAT_SYSREF_BIT = 0;
  localparam int unsigned STAT_LANE_B_OK_BIT = 1;
  localparam int unsigned STAT_TRIM_BIT = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [2:0] SWING_RESET = 3'h0;
  localparam logic [5:0] DEEMPH_RESET = 6'h00;
  localparam logic [1:0] LANE_B_UP_RESET = 2'h0;
  localparam logic [3:0] LANE_B_LOW_RESET = 4'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ************************************************************
  // Bus encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    DSCR_IDLE,
    DSCR_WRITE,
    DSCR_READ_WAIT,
    DSCR_READ_DONE
  } dscr_bus_state_type;

endpackage

`default_nettype wire

// File: core/dscr_sync.sv
/*
  Three-stage synchroniser for one asynchronous pin.
  Assumes the pin level is slow compared with clk; the output follows
  only once the second and third stages agree.
*/
`default_nettype none

module dscr_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  import dscr_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic dout_reg;
  logic dout_next;

  // ************************************************************
  // Filter
  // ************************************************************
  // First stage feeds only the second, so a metastable value never reaches logic
  always_comb begin
    dout_next = dout_reg;
    if (s2_reg == s3_reg) begin
      dout_next = s3_reg;
    end
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

endmodule

`default_nettype wire

// File: core/dscr_regs.sv
/*
  Configuration register bank of a quad-channel receiver converter:
  downconverter mode for the C/D pair, trim-load command, reference
  pulse masking, serial output swing and lane A/B de-emphasis codes.
  Assumes a single AHB-Lite master, word transfers only, and a reference
  pulse pin that is asynchronous to clk.
*/
// The implementer's own choice: the AHB-Lite interface to the registers.
`default_nettype none

// Overview of operation
// - Low nibble selects C/D downconverter mode
// - Reserved bits read zero, ignore writes
// - Writing trim bit one loads trims
// - Mask bit one blocks reference pulse
// - Swing field bits six to four
// - Lane A code, seven valid values
// - Top bits hold lane B upper
// - All fields reset to zero
// - Next register holds lane B lower

module dscr_regs #(
  parameter logic [31:0] DIGITAL_BASE = dscr_pkg::DIGITAL_PAGE_BASE,
  parameter logic [31:0] ANALOG_BASE = dscr_pkg::ANALOG_PAGE_BASE
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sysref_pin,
  output logic sysref_gated,
  output logic [3:0] downconv_select_pair_cd,
  output logic trim_load_trigger,
  output logic [2:0] serial_output_amplitude,
  output logic [5:0] lane_a_deemph_code,
  output logic [5:0] lane_b_deemph_code
);
  import dscr_pkg::*;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // Each page must sit on its own aligned window, or decoding would overlap
  if (DIGITAL_BASE[PAGE_SPAN_BITS-1:0] != '0 || ANALOG_BASE[PAGE_SPAN_BITS-1:0] != '0 ||
      DIGITAL_BASE[31:PAGE_SPAN_BITS] == ANALOG_BASE[31:PAGE_SPAN_BITS]) begin : g_bad_base
    $error("page bases must be distinct and aligned to the page span");
  end

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Address falls inside a page window
  function automatic logic in_page(input logic [31:0] addr, input logic [31:0] base);
    in_page = (addr[31:PAGE_SPAN_BITS] == base[31:PAGE_SPAN_BITS]);
  endfunction

  // De-emphasis code is one of 0, 1, 3, 7, 15, 31, 63 (a run of ones from bit 0)
  function automatic logic deemph_ok(input logic [5:0] code);
    deemph_ok = ((code & (code + 6'h01)) == 6'h00);
  endfunction

  // Downconverter modes 0 to 4 and 6 to 8 exist; 5 and 9 to 15 do not
  function automatic logic mode_ok(input logic [3:0] code);
    mode_ok = (code <= 4'h8) && (code != 4'h5);
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  dscr_bus_state_type state_reg;
  dscr_bus_state_type state_next;
  logic cap_dig_reg;
  logic cap_dig_next;
  logic cap_ana_reg;
  logic cap_ana_next;
  logic [7:0] cap_idx_reg;
  logic [7:0] cap_idx_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [31:0] rd_value;
  logic take;

  logic [3:0] mode_cd_reg;
  logic [3:0] mode_cd_next;
  logic trim_bit_reg;
  logic trim_bit_next;
  logic trim_pulse_reg;
  logic trim_pulse_next;
  logic sysref_mask_reg;
  logic sysref_mask_next;
  logic [2:0] swing_reg;
  logic [2:0] swing_next;
  logic [5:0] lane_a_reg;
  logic [5:0] lane_a_next;
  logic [1:0] lane_b_up_reg;
  logic [1:0] lane_b_up_next;
  logic [3:0] lane_b_low_reg;
  logic [3:0] lane_b_low_next;
  logic [5:0] lane_b_out_reg;
  logic [5:0] lane_b_out_next;
  logic sysref_gated_reg;
  logic sysref_gated_next;
  logic sysref_level;
  logic [5:0] lane_b_raw;
  logic [7:0] wbyte;
  logic wr_dig;
  logic wr_ana;

  // ************************************************************
  // Reference pulse input
  // ************************************************************
  dscr_sync u_sysref_sync (
    .clk(clk),
    .rstn(rstn),
    .din(sysref_pin),
    .dout(sysref_level)
  );

  // ************************************************************
  // Bus slave
  // ************************************************************
  // Address phase is taken only for NONSEQ or SEQ while the bus is ready
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // Reads add one wait state so read data always reflects a write that
  // finished in the cycle before; writes complete with no wait state
  always_comb begin
    state_next = state_reg;
    cap_dig_next = cap_dig_reg;
    cap_ana_next = cap_ana_reg;
    cap_idx_next = cap_idx_reg;
    hreadyout_next = 1'b1;
    hrdata_next = hrdata_reg;
    case (state_reg)
      DSCR_READ_WAIT: begin
        hrdata_next = rd_value;
        state_next = DSCR_READ_DONE;
      end
      default: begin
        if (take) begin
          cap_dig_next = in_page(haddr, DIGITAL_BASE);
          cap_ana_next = in_page(haddr, ANALOG_BASE);
          cap_idx_next = haddr[PAGE_SPAN_BITS-1:2];
          if (hwrite) begin
            state_next = DSCR_WRITE;
          end else begin
            state_next = DSCR_READ_WAIT;
            hreadyout_next = 1'b0;
          end
        end else begin
          state_next = DSCR_IDLE;
        end
      end
    endcase
  end

  // Bus state registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= DSCR_IDLE;
      cap_dig_reg <= 1'b0;
      cap_ana_reg <= 1'b0;
      cap_idx_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= WORD_ZERO;
    end else begin
      state_reg <= state_next;
      cap_dig_reg <= cap_dig_next;
      cap_ana_reg <= cap_ana_next;
      cap_idx_reg <= cap_idx_next;
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ************************************************************
  // Read decode
  // ************************************************************
  assign lane_b_raw = {lane_b_up_reg, lane_b_low_reg};

  // Unmapped offsets and reserved bits read as zero
  always_comb begin
    rd_value = WORD_ZERO;
    if (cap_dig_reg && cap_idx_reg == DOWNCONV_MODE_CD_IDX) begin
      rd_value[MODE_LSB +: MODE_W] = mode_cd_reg;
    end else if (cap_dig_reg && cap_idx_reg == TRIM_LOAD_COMMAND_IDX) begin
      rd_value[TRIM_BIT] = trim_bit_reg;
    end else if (cap_dig_reg && cap_idx_reg == CORE_STATUS_IDX) begin
      rd_value[STAT_SYSREF_BIT] = sysref_level;
      rd_value[STAT_LANE_B_OK_BIT] = deemph_ok(lane_b_raw);
      rd_value[STAT_TRIM_BIT] = trim_pulse_reg;
    end else if (cap_ana_reg && cap_idx_reg == SYSREF_GATE_CONTROL_IDX) begin
      rd_value[SYSREF_MASK_BIT] = sysref_mask_reg;
    end else if (cap_ana_reg && cap_idx_reg == SERIAL_SWING_SELECT_IDX) begin
      rd_value[SWING_LSB +: SWING_W] = swing_reg;
    end else if (cap_ana_reg && cap_idx_reg == LANE_AB_EMPHASIS_IDX) begin
      rd_value[LANE_A_LSB +: DEEMPH_W] = lane_a_reg;
      rd_value[LANE_B_UP_LSB +: LANE_B_UP_W] = lane_b_up_reg;
    end else if (cap_ana_reg && cap_idx_reg == LANE_B_EMPHASIS_LOW_IDX) begin
      rd_value[LANE_B_LOW_LSB +: LANE_B_LOW_W] = lane_b_low_reg;
    end
  end

  // ************************************************************
  // Configuration fields
  // ************************************************************
  assign wbyte = hwdata[7:0];
  assign wr_dig = (state_reg == DSCR_WRITE) && cap_dig_reg;
  assign wr_ana = (state_reg == DSCR_WRITE) && cap_ana_reg;

  // Writes land in the data phase; only defined field bits are stored
  always_comb begin
    mode_cd_next = mode_cd_reg;
    trim_bit_next = trim_bit_reg;
    trim_pulse_next = 1'b0;
    sysref_mask_next = sysref_mask_reg;
    swing_next = swing_reg;
    lane_a_next = lane_a_reg;
    lane_b_up_next = lane_b_up_reg;
    lane_b_low_next = lane_b_low_reg;
    if (wr_dig && cap_idx_reg == DOWNCONV_MODE_CD_IDX) begin
      // Unsupported modes are dropped so the datapath never sees them
      if (mode_ok(wbyte[MODE_LSB +: MODE_W])) begin
        mode_cd_next = wbyte[MODE_LSB +: MODE_W];
      end
    end else if (wr_dig && cap_idx_reg == TRIM_LOAD_COMMAND_IDX) begin
      trim_bit_next = wbyte[TRIM_BIT];
      trim_pulse_next = wbyte[TRIM_BIT];
    end else if (wr_ana && cap_idx_reg == SYSREF_GATE_CONTROL_IDX) begin
      sysref_mask_next = wbyte[SYSREF_MASK_BIT];
    end else if (wr_ana && cap_idx_reg == SERIAL_SWING_SELECT_IDX) begin
      swing_next = wbyte[SWING_LSB +: SWING_W];
    end else if (wr_ana && cap_idx_reg == LANE_AB_EMPHASIS_IDX) begin
      // A lane A code outside the run-of-ones set is ignored
      if (deemph_ok(wbyte[LANE_A_LSB +: DEEMPH_W])) begin
        lane_a_next = wbyte[LANE_A_LSB +: DEEMPH_W];
      end
      lane_b_up_next = wbyte[LANE_B_UP_LSB +: LANE_B_UP_W];
    end else if (wr_ana && cap_idx_reg == LANE_B_EMPHASIS_LOW_IDX) begin
      lane_b_low_next = wbyte[LANE_B_LOW_LSB +: LANE_B_LOW_W];
    end
  end

  // Lane B is written in two halves, so a half-updated code may be invalid;
  // the transmitter keeps the last valid code until both halves agree
  always_comb begin
    lane_b_out_next = lane_b_out_reg;
    if (deemph_ok(lane_b_raw)) begin
      lane_b_out_next = lane_b_raw;
    end
  end

  // Masked reference pulses never reach the timing logic
  always_comb begin
    sysref_gated_next = sysref_level && !sysref_mask_reg;
  end

  // Field registers, all zero after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_cd_reg <= MODE_RESET;
      trim_bit_reg <= 1'b0;
      trim_pulse_reg <= 1'b0;
      sysref_mask_reg <= 1'b0;
      swing_reg <= SWING_RESET;
      lane_a_reg <= DEEMPH_RESET;
      lane_b_up_reg <= LANE_B_UP_RESET;
      lane_b_low_reg <= LANE_B_LOW_RESET;
      lane_b_out_reg <= DEEMPH_RESET;
      sysref_gated_reg <= 1'b0;
    end else begin
      mode_cd_reg <= mode_cd_next;
      trim_bit_reg <= trim_bit_next;
      trim_pulse_reg <= trim_pulse_next;
      sysref_mask_reg <= sysref_mask_next;
      swing_reg <= swing_next;
      lane_a_reg <= lane_a_next;
      lane_b_up_reg <= lane_b_up_next;
      lane_b_low_reg <= lane_b_low_next;
      lane_b_out_reg <= lane_b_out_next;
      sysref_gated_reg <= sysref_gated_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = hreadyout_reg;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign sysref_gated = sysref_gated_reg;
  assign downconv_select_pair_cd = mode_cd_reg;
  assign trim_load_trigger = trim_pulse_reg;
  assign serial_output_amplitude = swing_reg;
  assign lane_a_deemph_code = lane_a_reg;
  assign lane_b_deemph_code = lane_b_out_reg;

endmodule

`default_nettype wire

// File: bench/dscr_regs_properties.sv
/*
  Concurrent checks on the ports of the converter register bank.
  Assumes the default page bases and a single bus master.
*/
`default_nettype none

module dscr_regs_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] downconv_select_pair_cd,
  input wire logic trim_load_trigger,
  input wire logic [5:0] lane_a_deemph_code,
  input wire logic [5:0] lane_b_deemph_code
);
  import dscr_pkg::*;
  localparam logic [31:0] A_MODE = DIGITAL_PAGE_BASE + {22'h0, DOWNCONV_MODE_CD_IDX, 2'h0};
  localparam logic [31:0] A_TRIM = DIGITAL_PAGE_BASE + {22'h0, TRIM_LOAD_COMMAND_IDX, 2'h0};
  localparam logic [31:0] A_LAB = ANALOG_PAGE_BASE + {22'h0, LANE_AB_EMPHASIS_IDX, 2'h0};
  localparam logic [31:0] D_LAB = DIGITAL_PAGE_BASE + {22'h0, LANE_AB_EMPHASIS_IDX, 2'h0};
  logic rd_take;

  // ************************************************************
  // Properties
  // ************************************************************
  // Read acceptance; the answer lands two edges later with one wait state
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_reset_all_zero: assert property ($rose(rstn) |-> hrdata == 32'h0 && downconv_select_pair_cd == 4'h0 &&
    lane_a_deemph_code == 6'h0 && lane_b_deemph_code == 6'h0 && !trim_load_trigger) else $error("not zero after reset");
  a_mode_code_legal: assert property (downconv_select_pair_cd inside {[4'h0:4'h4], [4'h6:4'h8]})
    else $error("illegal mode code");
  a_mode_write_cause: assert property ($changed(downconv_select_pair_cd) |-> $past(haddr, 2) == A_MODE &&
    $past(hwrite, 2) && $past(hsel, 2)) else $error("mode changed without a write");
  a_mode_rsvd_zero: assert property (rd_take && haddr == A_MODE |-> ##2 hrdata[7:4] == 4'h0)
    else $error("reserved mode bits not zero");
  a_trim_pulse_cause: assert property (trim_load_trigger |-> $past(hwdata[0]) && $past(haddr, 2) == A_TRIM &&
    $past(hwrite, 2)) else $error("trim pulse without a write of one");
  a_lane_a_legal: assert property (lane_a_deemph_code inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F})
    else $error("illegal lane A code");
  a_lane_a_cause: assert property ($changed(lane_a_deemph_code) |-> $past(haddr, 2) == A_LAB &&
    $past(hwrite, 2)) else $error("lane A changed without a write");
  a_lane_b_legal: assert property (lane_b_deemph_code inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F})
    else $error("illegal lane B code");
  a_page_separate: assert property (rd_take && haddr == D_LAB |-> ##1 !hready ##1 hrdata == 32'h0)
    else $error("digital page aliases analog register");
endmodule

bind dscr_regs dscr_regs_checker i_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .downconv_select_pair_cd(downconv_select_pair_cd), .trim_load_trigger(trim_load_trigger),
  .lane_a_deemph_code(lane_a_deemph_code), .lane_b_deemph_code(lane_b_deemph_code));

`default_nettype wire

// File: bench/tb_ddc_serdes_config_regs.sv
/*
  Self-checking bench for the converter register bank.
  Assumes one AHB-Lite slave whose ready output is the bus ready.
*/
`default_nettype none

module tb_ddc_serdes_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import dscr_pkg::*;
  localparam logic [31:0] A_MODE = DIGITAL_PAGE_BASE + {22'h0, DOWNCONV_MODE_CD_IDX, 2'h0};
  localparam logic [31:0] A_TRIM = DIGITAL_PAGE_BASE + {22'h0, TRIM_LOAD_COMMAND_IDX, 2'h0};
  localparam logic [31:0] A_SREF = ANALOG_PAGE_BASE + {22'h0, SYSREF_GATE_CONTROL_IDX, 2'h0};
  localparam logic [31:0] A_SWING = ANALOG_PAGE_BASE + {22'h0, SERIAL_SWING_SELECT_IDX, 2'h0};
  localparam logic [31:0] A_LAB = ANALOG_PAGE_BASE + {22'h0, LANE_AB_EMPHASIS_IDX, 2'h0};
  localparam logic [31:0] A_LB = ANALOG_PAGE_BASE + {22'h0, LANE_B_EMPHASIS_LOW_IDX, 2'h0};
  localparam logic [31:0] D_LAB = DIGITAL_PAGE_BASE + {22'h0, LANE_AB_EMPHASIS_IDX, 2'h0};
  localparam logic [31:0] A_STAT = DIGITAL_PAGE_BASE + {22'h0, CORE_STATUS_IDX, 2'h0};
  localparam logic [31:0] REGS [6] = '{A_MODE, A_TRIM, A_SREF, A_SWING, A_LAB, A_LB};
  localparam logic [3:0] MODES [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
  localparam logic [3:0] BAD_MODES [3] = '{4'h5, 4'h9, 4'hF};
  localparam logic [5:0] LANES [7] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F};
  logic clk, rstn, hsel, hwrite, sysref_pin, hready, hresp, sysref_gated, trig;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, amp;
  logic [3:0] mode;
  logic [5:0] lane_a, lane_b;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  dscr_regs i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .sysref_pin(sysref_pin), .sysref_gated(sysref_gated), .downconv_select_pair_cd(mode),
    .trim_load_trigger(trig), .serial_output_amplitude(amp), .lane_a_deemph_code(lane_a),
    .lane_b_deemph_code(lane_b));

  // ************************************************************
  // Bus and report tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Entered just after a rising edge; holds each phase until ready is sampled high
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    check("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(name, {24'h0, exp}, rd);
  endtask

  task automatic give_verdict();
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, timeout and test sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run needs well under 1000 cycles; a hang ends here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {rstn, hsel, hwrite, sysref_pin, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd_chk("reset value", REGS[i], 8'h00);
    check("reset outputs", 32'h0, {11'h0, mode, amp, lane_a, lane_b, trig, sysref_gated});
    // Every legal mode; software keeps reserved bits at zero
    for (int i = 0; i < 8; i++) begin
      wr(A_MODE, {4'h0, MODES[i]});
      rd_chk("mode readback", A_MODE, {4'h0, MODES[i]});
      check("mode output", {28'h0, MODES[i]}, {28'h0, mode});
    end
    for (int i = 0; i < 3; i++) begin
      wr(A_MODE, {4'h0, BAD_MODES[i]});
      rd_chk("mode kept", A_MODE, 8'h08);
      check("mode output kept", 32'h8, {28'h0, mode});
    end
    for (int i = 0; i < 8; i++) begin
      wr(A_SWING, {1'b0, i[2:0], 4'h0});
      rd_chk("swing readback", A_SWING, {1'b0, i[2:0], 4'h0});
      check("swing output", i, {29'h0, amp});
    end
    for (int i = 0; i < 7; i++) begin
      wr(A_LAB, {2'h0, LANES[i]});
      rd_chk("lane A readback", A_LAB, {2'h0, LANES[i]});
      check("lane A output", {26'h0, LANES[i]}, {26'h0, lane_a});
    end
    // Lane B upper bits land beside an unchanged lane A code
    wr(A_LAB, 8'hFF);
    rd_chk("lane A kept", A_LAB, 8'hFF);
    check("lane A output kept", 32'h3F, {26'h0, lane_a});
    wr(A_LB, 8'h0F);
    rd_chk("lane B lower", A_LB, 8'h0F);
    check("lane B output", 32'h3F, {26'h0, lane_b});
    wr(A_LB, 8'h01);
    rd_chk("lane B lower", A_LB, 8'h01);
    check("lane B held", 32'h3F, {26'h0, lane_b});
    wr(A_LAB, 8'h3F);
    rd_chk("lane B upper", A_LAB, 8'h3F);
    check("lane B joined", 32'h01, {26'h0, lane_b});
    // Same index on the other page is a different place
    wr(D_LAB, 8'h00);
    rd_chk("other page", D_LAB, 8'h00);
    check("lane A untouched", 32'h3F, {26'h0, lane_a});
    rd_chk("unmapped", A_SWING + 32'h4, 8'h00);
    wr(A_TRIM, 8'h01);
    #1 check("trim pulse", 32'h1, {31'h0, trig});
    @(posedge clk);
    #1 check("trim pulse end", 32'h0, {31'h0, trig});
    @(posedge clk);
    rd_chk("trim readback", A_TRIM, 8'h01);
    // Reference pulse with the mask clear, then set
    for (int m = 0; m < 2; m++) begin
      wr(A_SREF, {6'h00, m[0], 1'b0});
      rd_chk("mask readback", A_SREF, {6'h0, m[0], 1'b0});
      sysref_pin <= 1'b1;
      repeat (8) @(posedge clk);
      check("reference pass", {31'h0, !m[0]}, {31'h0, sysref_gated});
      sysref_pin <= 1'b0;
      repeat (8) @(posedge clk);
      check("reference idle", 32'h0, {31'h0, sysref_gated});
    end
    // Status: reference low, joined lane B code 01 valid, no trim pulse
    rd_chk("status", A_STAT, 8'h02);
    give_verdict();
  end
endmodule

`default_nettype wire
